// ### hw/adc_ctl_consts.svh
// Constants for the converter clock, power and output-format control
// Contract
// - Divide-select pin low gives divide by 2, floating 1, high 4.
// - Divide ratio written over the configuration port overrides the pin.
// - DLL relock after clock change takes a fixed count of sample cycles.
// - DLL offers a slow and a fast range; fast is the default.
// - Samples leave as a parallel DDR bus, LVDS by default or CMOS.
// - LVDS drive current is 3mA by default or a reduced 2mA.
// - Signalling mode and data coding are set in register 0x73.
// - Nap or sleep puts data, forwarded clock and over-range in high-Z.
// - After power-on the power-mode pin picks normal, sleep or nap.
// - Power mode written over the configuration port overrides the pin.
// - Codings are two's complement (default), Gray and offset binary.
// - Offset binary maps most negative to all zeros, most positive to ones.
// - Two's complement is offset binary with its top bit inverted.
// - Gray keeps the top bit; lower bits XOR with next higher bit.
// - Divider runs the sample clock at a half or a quarter rate.
// - Forwarded clock keeps a fixed phase to the sample clock.
// - Divider sync pulse realigns sample and forwarded clock phases; the code resets the divider count, not the forwarded clock.
// - After a sync, data follows after the fixed pipeline latency.
// - Before a sync either divide-by-two phase may occur.
// - Data appears 10 sample cycles after the sampling instant; the code updates sample_out 11 sample cycles after it.
// - Under divide 2 or 4, forwarded clock held low during cal reset.
`ifndef ADC_CTL_CONSTS_SVH
`define ADC_CTL_CONSTS_SVH

`define SAMPLE_BITS        16
`define PIPE_LATENCY       10
`define RELOCK_TIME_US     52
`define RELOCK_RATE_MSPS   250
`define RELOCK_SAMPLES     (`RELOCK_TIME_US * `RELOCK_RATE_MSPS)

`define ADDR_CLK_DIV       8'h71
`define ADDR_POWER         8'h72
`define ADDR_OUT_FORMAT    8'h73
`define ADDR_STATUS        8'h74

`define DIVIDE_SELECT_PIN_RATIO_LSB   0
`define DIVIDE_SELECT_PIN_OVR_BIT     2
`define DIVIDE_SELECT_PIN_SLOW_BIT    3
`define DIVIDE_SELECT_PIN_RESET       8'h00

`define POWER_MODE_LSB     0
`define POWER_OVR_BIT      2
`define POWER_RESET        8'h00

`define FMT_CODING_LSB     0
`define FMT_CMOS_BIT       4
`define FMT_LOWDRV_BIT     5
`define FMT_RESET          8'h00

`define STAT_LOCK_BIT      0
`define STAT_RATIO_LSB     1
`define STAT_POWER_LSB     3
`define STAT_ALIGN_BIT     5

`endif

// ### hw/adc_ctl_pkg.sv
// Types shared by the converter control block
package adc_ctl_pkg;
   // Pin level codes: tied low, floating, tied high
   typedef enum logic [1:0] {
      PIN_LOW   = 2'h0,
      PIN_FLOAT = 2'h1,
      PIN_HIGH  = 2'h2
   } pin_level_t;
   typedef enum logic [1:0] {
      RATIO_1 = 2'h0,
      RATIO_2 = 2'h1,
      RATIO_4 = 2'h2
   } div_ratio_t;
   typedef enum logic [1:0] {
      PWR_NORMAL = 2'h0,
      PWR_SLEEP  = 2'h1,
      PWR_NAP    = 2'h2
   } power_mode_t;
   typedef enum logic [1:0] {
      CODE_TWOS   = 2'h0,
      CODE_GRAY   = 2'h1,
      CODE_OFFSET = 2'h2
   } coding_t;
endpackage : adc_ctl_pkg

// ### hw/sample_divider.sv
// Sample clock divider with synchronous phase realignment
`timescale 1ns/100ps
`include "adc_ctl_consts.svh"
module sample_divider (
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   input  wire adc_ctl_pkg::div_ratio_t ratio,
   input  wire logic                   sync_pulse,
   output logic                        sample_en,
   output logic                        aligned
);
   logic [1:0] cnt_r;
   logic [1:0] last_cnt;

   always_comb begin
      case (ratio)
         adc_ctl_pkg::RATIO_2: last_cnt = 2'h1;
         adc_ctl_pkg::RATIO_4: last_cnt = 2'h3;
         default:              last_cnt = 2'h0;
      endcase
   end

   // Phase out of reset is arbitrary until the first sync pulse
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 2'h0;
      end else if (sync_pulse && ratio != adc_ctl_pkg::RATIO_1) begin
         cnt_r <= 2'h0;
      end else if (cnt_r >= last_cnt) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aligned <= 1'b0;
      end else if (sync_pulse && ratio != adc_ctl_pkg::RATIO_1) begin
         aligned <= 1'b1;
      end
   end

   assign sample_en = (cnt_r == 2'h0);
endmodule : sample_divider

// ### hw/skid_buffer.sv
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/100ps
module skid_buffer #(
   parameter int WIDTH = 17
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   logic [WIDTH-1:0] mem_r [2];
   logic             rd_r;
   logic             wr_r;
   logic [1:0]       cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 2'h0;
         rd_r  <= 1'b0;
         wr_r  <= 1'b0;
      end else begin
         if (push) begin
            wr_r <= ~wr_r;
         end
         if (pop) begin
            rd_r <= ~rd_r;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 2'h1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 2'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end
endmodule : skid_buffer

// ### hw/adc_ctl_top.sv
// Clock divider, power mode, DLL lock and output formatting control
`timescale 1ns/100ps
`include "adc_ctl_consts.svh"
module adc_ctl_top #(
   parameter int RELOCK_SAMPLES = `RELOCK_SAMPLES
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  divide_select_pin,
   input  wire logic [1:0]  power_mode_pin,
   input  wire logic        divider_sync_reset_pos,
   input  wire logic        divider_sync_reset_neg,
   input  wire logic        calibration_reset_low,
   input  wire logic        chip_select_low,
   input  wire logic        cfg_wr_en,
   input  wire logic        cfg_rd_en,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [7:0]  cfg_wdata,
   output logic [7:0]       cfg_rdata,
   input  wire logic [15:0] core_data,
   input  wire logic        core_over_range,
   input  wire logic        capture_ready,
   output logic [15:0]      sample_out,
   output logic             sample_out_oe,
   output logic             over_range_out,
   output logic             over_range_oe,
   output logic             forwarded_clock_pos,
   output logic             forwarded_clock_neg,
   output logic             forwarded_clock_oe,
   output logic             out_cmos_mode,
   output logic             out_low_drive,
   output logic             dll_slow_range,
   output logic             dll_locked,
   output logic             sample_clk_en
);
   localparam int W = `SAMPLE_BITS;
   localparam int L = `PIPE_LATENCY;

   // Two-flop synchronisers for every pin input
   logic [7:0] pin_s1_r;
   logic [7:0] pin_s2_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= 8'hc0;
         pin_s2_r <= 8'hc0;
      end else begin
         pin_s1_r <= {chip_select_low, calibration_reset_low,
                      divider_sync_reset_neg, divider_sync_reset_pos,
                      power_mode_pin, divide_select_pin};
         pin_s2_r <= pin_s1_r;
      end
   end

   logic [1:0] div_pin_s;
   logic [1:0] pwr_pin_s;
   logic       srst_pos_s;
   logic       srst_neg_s;
   logic       cal_low_s;
   logic       cs_low_s;
   assign div_pin_s  = pin_s2_r[1:0];
   assign pwr_pin_s  = pin_s2_r[3:2];
   assign srst_pos_s = pin_s2_r[4];
   assign srst_neg_s = pin_s2_r[5];
   assign cal_low_s  = pin_s2_r[6];
   assign cs_low_s   = pin_s2_r[7];

   // Configuration registers
   logic [7:0] clk_div_r;
   logic [7:0] power_r;
   logic [7:0] fmt_r;
   logic       wr_ok;
   assign wr_ok = cfg_wr_en && !cs_low_s;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clk_div_r <= `DIVIDE_SELECT_PIN_RESET;
      end else if (wr_ok && cfg_addr == `ADDR_CLK_DIV) begin
         clk_div_r <= cfg_wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         power_r <= `POWER_RESET;
      end else if (wr_ok && cfg_addr == `ADDR_POWER) begin
         power_r <= cfg_wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fmt_r <= `FMT_RESET;
      end else if (wr_ok && cfg_addr == `ADDR_OUT_FORMAT) begin
         fmt_r <= cfg_wdata;
      end
   end

   // Effective divide ratio
   adc_ctl_pkg::div_ratio_t ratio;
   always_comb begin
      if (clk_div_r[`DIVIDE_SELECT_PIN_OVR_BIT]) begin
         ratio = adc_ctl_pkg::div_ratio_t'(
                    clk_div_r[`DIVIDE_SELECT_PIN_RATIO_LSB +: 2]);
      end else begin
         case (adc_ctl_pkg::pin_level_t'(div_pin_s))
            adc_ctl_pkg::PIN_LOW:   ratio = adc_ctl_pkg::RATIO_2;
            adc_ctl_pkg::PIN_FLOAT: ratio = adc_ctl_pkg::RATIO_1;
            adc_ctl_pkg::PIN_HIGH:  ratio = adc_ctl_pkg::RATIO_4;
            default:                ratio = adc_ctl_pkg::RATIO_1;
         endcase
      end
   end

   // Power mode: pin unless the register overrides it
   adc_ctl_pkg::power_mode_t pmode;
   always_comb begin
      if (power_r[`POWER_OVR_BIT]) begin
         pmode = adc_ctl_pkg::power_mode_t'(
                    power_r[`POWER_MODE_LSB +: 2]);
      end else begin
         case (adc_ctl_pkg::pin_level_t'(pwr_pin_s))
            adc_ctl_pkg::PIN_LOW:   pmode = adc_ctl_pkg::PWR_NORMAL;
            adc_ctl_pkg::PIN_FLOAT: pmode = adc_ctl_pkg::PWR_SLEEP;
            adc_ctl_pkg::PIN_HIGH:  pmode = adc_ctl_pkg::PWR_NAP;
            default:                pmode = adc_ctl_pkg::PWR_NORMAL;
         endcase
      end
   end

   logic outputs_on;
   assign outputs_on = (pmode == adc_ctl_pkg::PWR_NORMAL);

   // Divider sync: rising edge of a complementary pair
   logic srst_lvl;
   logic srst_prev_r;
   logic sync_pulse;
   assign srst_lvl = srst_pos_s && !srst_neg_s;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         srst_prev_r <= 1'b0;
      end else begin
         srst_prev_r <= srst_lvl;
      end
   end
   assign sync_pulse = srst_lvl && !srst_prev_r;

   logic sample_en;
   logic aligned;
   sample_divider u_div (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .ratio      (ratio),
      .sync_pulse (sync_pulse),
      .sample_en  (sample_en),
      .aligned    (aligned)
   );
   assign sample_clk_en = sample_en;

   // DLL lock model: relock counted in sample cycles, so its wall time
   // scales inversely with the sample rate
   logic [1:0] ratio_prev_r;
   logic       slow_prev_r;
   logic [31:0] relock_r;
   logic       clk_change;
   assign dll_slow_range = clk_div_r[`DIVIDE_SELECT_PIN_SLOW_BIT];
   assign clk_change = (ratio_prev_r != ratio) ||
                       (slow_prev_r != dll_slow_range);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ratio_prev_r <= 2'h0;
         slow_prev_r  <= 1'b0;
      end else begin
         ratio_prev_r <= ratio;
         slow_prev_r  <= dll_slow_range;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         relock_r <= 32'h0;
      end else if (clk_change) begin
         relock_r <= 32'(RELOCK_SAMPLES);
      end else if (sample_en && relock_r != 32'h0) begin
         relock_r <= relock_r - 32'h1;
      end
   end
   assign dll_locked = (relock_r == 32'h0);

   // Sample pipeline, stalls only when the buffer is full
   logic [W:0] pipe_r [L];
   logic [L-1:0] pvld_r;
   logic       buf_in_ready;
   logic       advance;
   assign advance = sample_en && buf_in_ready;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pvld_r <= '0;
      end else if (advance) begin
         pvld_r <= {pvld_r[L-2:0], 1'b1};
      end
   end

   genvar g;
   generate
      for (g = 0; g < L; g++) begin : g_pipe
         always_ff @(posedge mclk) begin
            if (advance) begin
               if (g == 0) begin
                  pipe_r[g] <= {core_over_range, core_data};
               end else begin
                  pipe_r[g] <= pipe_r[g == 0 ? 0 : g - 1];
               end
            end
         end
      end
   endgenerate

   // Coding applied after the core result at full width
   logic [W-1:0] ob;
   logic [W-1:0] coded;
   assign ob = pipe_r[L-1][W-1:0];
   always_comb begin
      case (adc_ctl_pkg::coding_t'(fmt_r[`FMT_CODING_LSB +: 2]))
         adc_ctl_pkg::CODE_TWOS:
            coded = {~ob[W-1], ob[W-2:0]};
         adc_ctl_pkg::CODE_GRAY:
            coded = ob ^ {1'b0, ob[W-1:1]};
         adc_ctl_pkg::CODE_OFFSET:
            coded = ob;
         default:
            coded = {~ob[W-1], ob[W-2:0]};
      endcase
   end

   logic         buf_out_valid;
   logic [W:0]   buf_out_data;
   logic         pop;
   assign pop = sample_en && capture_ready && buf_out_valid;

   skid_buffer #(.WIDTH(W + 1)) u_buf (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_valid  (advance && pvld_r[L-1]),
      .in_ready  (buf_in_ready),
      .in_data   ({pipe_r[L-1][W], coded}),
      .out_valid (buf_out_valid),
      .out_ready (sample_en && capture_ready),
      .out_data  (buf_out_data)
   );

   // One word per forwarded clock edge gives double data rate
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sample_out     <= '0;
         over_range_out <= 1'b0;
      end else if (pop) begin
         sample_out     <= buf_out_data[W-1:0];
         over_range_out <= buf_out_data[W];
      end
   end

   // Forwarded clock toggles on each sample strobe
   logic fwd_r;
   logic hold_low;
   assign hold_low = !cal_low_s && ratio != adc_ctl_pkg::RATIO_1;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fwd_r <= 1'b0;
      end else if (hold_low) begin
         fwd_r <= 1'b0;
      end else if (sample_en) begin
         fwd_r <= ~fwd_r;
      end
   end
   assign forwarded_clock_pos = fwd_r;
   assign forwarded_clock_neg = ~fwd_r;

   // Drivers released in nap and sleep
   assign sample_out_oe      = outputs_on;
   assign over_range_oe      = outputs_on;
   assign forwarded_clock_oe = outputs_on;

   assign out_cmos_mode = fmt_r[`FMT_CMOS_BIT];
   assign out_low_drive = fmt_r[`FMT_LOWDRV_BIT] &&
                          !fmt_r[`FMT_CMOS_BIT];

   // Read port, unmapped addresses read zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata <= 8'h00;
      end else if (cfg_rd_en && !cs_low_s) begin
         case (cfg_addr)
            `ADDR_CLK_DIV:    cfg_rdata <= clk_div_r;
            `ADDR_POWER:      cfg_rdata <= power_r;
            `ADDR_OUT_FORMAT: cfg_rdata <= fmt_r;
            `ADDR_STATUS:     cfg_rdata <= {2'h0, aligned, pmode,
                                            ratio, dll_locked};
            default:          cfg_rdata <= 8'h00;
         endcase
      end
   end
endmodule : adc_ctl_top

// ### sim/adc_ctl_top_asserts.sv
// Port-level assertions for the converter control block
`timescale 1ns/100ps
module adc_ctl_top_asserts #(
   parameter int RELOCK_SAMPLES = 8
) (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        chip_select_low,
   input wire logic        cfg_wr_en,
   input wire logic        cfg_rd_en,
   input wire logic [7:0]  cfg_addr,
   input wire logic [7:0]  cfg_wdata,
   input wire logic [7:0]  cfg_rdata,
   input wire logic [15:0] sample_out,
   input wire logic        sample_out_oe,
   input wire logic        over_range_oe,
   input wire logic        forwarded_clock_pos,
   input wire logic        forwarded_clock_neg,
   input wire logic        forwarded_clock_oe,
   input wire logic        out_cmos_mode,
   input wire logic        out_low_drive,
   input wire logic        dll_locked,
   input wire logic        sample_clk_en
);
   localparam int RELOCK_LIMIT = 4 * RELOCK_SAMPLES + 16;
   int         unlock_cnt_r;
   logic [2:0] sel_hist_r;
   logic       sel_ok;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // Select passes a synchroniser, so it must have settled low
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_cnt_r <= 0;
         sel_hist_r   <= 3'h7;
      end else begin
         unlock_cnt_r <= dll_locked ? 0 : unlock_cnt_r + 1;
         sel_hist_r   <= {sel_hist_r[1:0], chip_select_low};
      end
   end
   assign sel_ok = (sel_hist_r == 3'h0) && !chip_select_low;

   a_fwd_compl: assert property (
      forwarded_clock_oe |-> forwarded_clock_neg != forwarded_clock_pos)
      else $error("clock legs not complementary");
   a_oe_together: assert property (
      sample_out_oe == forwarded_clock_oe && over_range_oe == sample_out_oe)
      else $error("output enables disagree");
   a_lowdrv_lvds: assert property (
      out_low_drive |-> !out_cmos_mode)
      else $error("low drive outside LVDS");
   a_fwd_on_strobe: assert property (
      $rose(forwarded_clock_pos) |-> $past(sample_clk_en))
      else $error("clock rose off a strobe");
   a_word_on_pop: assert property (
      $changed(sample_out) |-> $past(sample_clk_en))
      else $error("word changed off a strobe");
   a_relock_bound: assert property (
      unlock_cnt_r <= RELOCK_LIMIT)
      else $error("relock took too long");
   a_unmapped_zero: assert property (
      cfg_rd_en && sel_ok && cfg_addr > 8'h74 |=> cfg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_fmt_apply: assert property (
      cfg_wr_en && sel_ok && cfg_addr == 8'h73 |=>
      out_cmos_mode == $past(cfg_wdata[4]) &&
      out_low_drive == ($past(cfg_wdata[5]) && !$past(cfg_wdata[4])))
      else $error("format write not applied");
endmodule : adc_ctl_top_asserts

bind adc_ctl_top adc_ctl_top_asserts #(
   .RELOCK_SAMPLES(RELOCK_SAMPLES)
) chk (
   .mclk, .rst_n, .chip_select_low, .cfg_wr_en, .cfg_rd_en, .cfg_addr,
   .cfg_wdata, .cfg_rdata, .sample_out, .sample_out_oe, .over_range_oe,
   .forwarded_clock_pos, .forwarded_clock_neg, .forwarded_clock_oe,
   .out_cmos_mode, .out_low_drive, .dll_locked, .sample_clk_en
);

// ### sim/capture_model.sv
// Capture-side model latching one word per forwarded clock edge
`timescale 1ns/100ps
module capture_model (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        slow,
   input  wire logic        gray,
   input  wire logic        arm,
   input  wire logic [15:0] data,
   input  wire logic        fwd_pos,
   output logic             capture_ready,
   output int               words,
   output int               errs,
   output logic [15:0]      last_word
);
   logic [15:0] bin;
   logic        pos_r;
   logic [1:0]  cnt_r;
   logic        took_r;
   always_comb begin
      bin[15] = data[15];
      for (int i = 14; i >= 0; i--) begin
         bin[i] = gray ? bin[i+1] ^ data[i] : data[i];
      end
   end
   // Slow mode takes one cycle in four; stalled edges repeat a word
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 2'h0;
         capture_ready <= 1'b1;
         took_r <= 1'b0;
         pos_r <= 1'b0;
         words <= 0;
         errs <= 0;
         last_word <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 2'h1;
         capture_ready <= !slow || cnt_r == 2'h3;
         took_r <= capture_ready;
         pos_r <= fwd_pos;
         if (!arm) begin
            words <= 0;
         end else if (fwd_pos != pos_r && took_r) begin
            words <= words + 1;
            if (words > 0 && bin <= last_word) begin
               errs <= errs + 1;
            end
            last_word <= bin;
         end
      end
   end
endmodule : capture_model

// ### sim/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module testbench;
   localparam int RELOCK = 8;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [1:0]  divide_select_pin = 2'h1;
   logic [1:0]  power_mode_pin = 2'h0;
   logic        divider_sync_reset_pos = 1'b0;
   logic        divider_sync_reset_neg = 1'b1;
   logic        calibration_reset_low = 1'b1;
   logic        chip_select_low = 1'b1;
   logic        cfg_wr_en = 1'b0;
   logic        cfg_rd_en = 1'b0;
   logic [7:0]  cfg_addr = 8'h00;
   logic [7:0]  cfg_wdata = 8'h00;
   logic [15:0] core_data = 16'h0000;
   logic        core_over_range = 1'b0;
   logic        slow = 1'b0;
   logic        gray = 1'b0;
   logic        arm = 1'b0;
   logic [7:0]  cfg_rdata;
   logic [15:0] sample_out, last_word;
   logic        capture_ready, sample_out_oe, over_range_out, over_range_oe;
   logic        forwarded_clock_pos, forwarded_clock_neg, forwarded_clock_oe;
   logic        out_cmos_mode, out_low_drive, dll_slow_range, dll_locked;
   logic        sample_clk_en;
   int          words, errs;
   int          miscompares = 0;
   int          num_checks = 0;

   always #5 mclk = ~mclk;

   adc_ctl_top #(.RELOCK_SAMPLES(RELOCK)) uut (
      .mclk, .rst_n, .divide_select_pin, .power_mode_pin,
      .divider_sync_reset_pos, .divider_sync_reset_neg,
      .calibration_reset_low, .chip_select_low, .cfg_wr_en, .cfg_rd_en,
      .cfg_addr, .cfg_wdata, .cfg_rdata, .core_data, .core_over_range,
      .capture_ready, .sample_out, .sample_out_oe, .over_range_out,
      .over_range_oe, .forwarded_clock_pos, .forwarded_clock_neg,
      .forwarded_clock_oe, .out_cmos_mode, .out_low_drive, .dll_slow_range,
      .dll_locked, .sample_clk_en
   );
   capture_model cap (
      .mclk, .rst_n, .slow, .gray, .arm, .data(sample_out),
      .fwd_pos(forwarded_clock_pos), .errs, .capture_ready, .words, .last_word
   );

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp,
                          input string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp_val
   task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr_en = 1'b1;
      tick(1);
      cfg_wr_en = 1'b0;
      tick(1);
   endtask : cfg_wr
   task automatic cfg_rd(input logic [7:0] a, input logic [7:0] exp);
      cfg_addr = a;
      cfg_rd_en = 1'b1;
      tick(1);
      cfg_rd_en = 1'b0;
      tick(1);
      cmp_val(16'(cfg_rdata), 16'(exp), "register read");
   endtask : cfg_rd
   task automatic wait_lock();
      int n;
      n = 0;
      while (dll_locked !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      cmp_val(16'(dll_locked), 16'h1, "relock");
   endtask : wait_lock
   // Every call changes the ratio, so the lock must drop first
   task automatic set_div(input logic [1:0] pin);
      divide_select_pin = pin;
      tick(5);
      cmp_val(16'(dll_locked), 16'h0, "lock drop");
      wait_lock();
   endtask : set_div
   task automatic period(input logic [15:0] exp);
      int n;
      n = 0;
      while (sample_clk_en !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      n = 0;
      do begin
         tick(1);
         n++;
      end while (sample_clk_en !== 1'b1 && n < 20);
      cmp_val(16'(n), exp, "strobe period");
   endtask : period
   task automatic chk_oe(input logic [15:0] exp);
      cmp_val(16'({sample_out_oe, over_range_oe, forwarded_clock_oe}), exp,
              "output enables");
   endtask : chk_oe
   task automatic chk_code(input int c, input logic [15:0] v);
      logic [15:0] exp;
      exp = (c == 0) ? v ^ 16'h8000 : (c == 1) ? v ^ (v >> 1) : v;
      core_data = v;
      tick(40);
      cmp_val(sample_out, exp, "coded word");
   endtask : chk_code

   task automatic t_reset();
      chip_select_low = 1'b0;
      tick(4);
      wait_lock();
      cfg_rd(8'h71, 8'h00);
      cfg_rd(8'h72, 8'h00);
      cfg_rd(8'h73, 8'h00);
      cfg_rd(8'h80, 8'h00);
      cmp_val(16'(dll_slow_range), 16'h0, "dll range");
   endtask : t_reset
   task automatic t_divider();
      logic [1:0]  pins [3] = '{2'h0, 2'h1, 2'h2};
      logic [15:0] per [3] = '{16'h2, 16'h1, 16'h4};
      for (int i = 0; i < 3; i++) begin
         set_div(pins[i]);
         period(per[i]);
      end
      set_div(2'h0);
      cfg_wr(8'h71, 8'h0e);
      cmp_val(16'(dll_slow_range), 16'h1, "dll range");
      wait_lock();
      period(16'h4);
      cfg_rd(8'h74, 8'h05);
      cfg_wr(8'h71, 8'h00);
      wait_lock();
      period(16'h2);
   endtask : t_divider
   task automatic t_power();
      logic [1:0]  pins [3] = '{2'h0, 2'h1, 2'h2};
      logic [15:0] oe [3] = '{16'h7, 16'h0, 16'h0};
      chip_select_low = 1'b1;
      for (int i = 0; i < 3; i++) begin
         power_mode_pin = pins[i];
         tick(5);
         chk_oe(oe[i]);
      end
      power_mode_pin = 2'h0;
      chip_select_low = 1'b0;
      tick(5);
      cfg_wr(8'h72, 8'h06);
      chk_oe(16'h0);
      cfg_rd(8'h74, 8'h13);
      cfg_wr(8'h72, 8'h00);
      chk_oe(16'h7);
   endtask : t_power
   task automatic t_format();
      logic [15:0] vals [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h1234};
      logic [7:0]  fmt [3] = '{8'h10, 8'h20, 8'h30};
      logic [15:0] drv [3] = '{16'h2, 16'h1, 16'h2};
      logic [15:0] got;
      core_over_range = 1'b1;
      for (int c = 0; c < 3; c++) begin
         cfg_wr(8'h73, 8'(c));
         cfg_rd(8'h73, 8'(c));
         for (int v = 0; v < 4; v++) begin
            chk_code(c, vals[v]);
         end
      end
      cmp_val(16'(over_range_out), 16'h1, "over range");
      core_over_range = 1'b0;
      for (int i = 0; i < 3; i++) begin
         cfg_wr(8'h73, fmt[i]);
         got = 16'({out_cmos_mode, out_low_drive});
         cmp_val(got, drv[i], "drive mode");
      end
      cfg_wr(8'h73, 8'h00);
   endtask : t_format
   task automatic t_stream();
      set_div(2'h1);
      cfg_wr(8'h73, 8'h01);
      gray = 1'b1;
      core_data = 16'h0100;
      for (int i = 0; i < 360; i++) begin
         tick(1);
         core_data = core_data + 16'h1;
         arm = i > 64;
         slow = i < 300;
      end
      cmp_val(16'(errs), 16'h0, "word order");
      cmp_val(16'(words > 60), 16'h1, "word count");
      tick(60);
      cmp_val(last_word, core_data, "drained word");
      arm = 1'b0;
      gray = 1'b0;
      cfg_wr(8'h73, 8'h00);
   endtask : t_stream
   task automatic t_sync();
      logic ph [2];
      set_div(2'h0);
      for (int i = 0; i < 2; i++) begin
         tick(i + 1);
         divider_sync_reset_pos = 1'b1;
         divider_sync_reset_neg = 1'b0;
         tick(1);
         divider_sync_reset_pos = 1'b0;
         divider_sync_reset_neg = 1'b1;
         tick(8);
         ph[i] = sample_clk_en;
      end
      cmp_val(16'(ph[1]), 16'(ph[0]), "sync phase");
      cfg_rd(8'h74, 8'h23);
      period(16'h2);
   endtask : t_sync
   task automatic t_cal();
      int n;
      n = 0;
      calibration_reset_low = 1'b0;
      tick(4);
      repeat (6) begin
         tick(1);
         cmp_val(16'(forwarded_clock_pos), 16'h0, "held clock");
      end
      calibration_reset_low = 1'b1;
      while (forwarded_clock_pos !== 1'b1 && n < 12) begin
         tick(1);
         n++;
      end
      cmp_val(16'(forwarded_clock_pos), 16'h1, "clock resumes");
   endtask : t_cal

   task automatic stop_test();
      $display("Checks %0d, miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      tick(20);
      rst_n = 1'b1;
      t_reset();
      t_divider();
      t_power();
      t_format();
      t_stream();
      t_sync();
      t_cal();
      stop_test();
   end
   // Whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      stop_test();
   end
endmodule : testbench
